/* File: logic/fwp_cfg.svh */
// Constants of the flash write-protection block: opcodes, status layout, timing, limits.
// Assumes inclusion ahead of the package-importing modules; holds definitions only.
`ifndef FWP_CFG_SVH
`define FWP_CFG_SVH
`define FWP_OP_STATUS_WRITE_CMD 8'h01
`define FWP_OP_PP 8'h02
`define FWP_OP_WRDI 8'h04
`define FWP_OP_RDSR 8'h05
`define FWP_OP_WRITE_ENABLE_CMD 8'h06
`define FWP_OP_SE 8'h20
`define FWP_OP_BE32 8'h52
`define FWP_OP_CE2 8'h60
`define FWP_OP_WAKE 8'hAB
`define FWP_OP_DPD 8'hB9
`define FWP_OP_CE1 8'hC7
`define FWP_OP_BE64 8'hD8
`define FWP_SR_LOCK 7
`define FWP_SR_BP_HI 4
`define FWP_SR_BP_LO 2
`define FWP_SR_WEL 1
`define FWP_SR_BUSY 0
`define FWP_LOCK_RESET 1'b0
`define FWP_BP_RESET 3'h0
`define FWP_BYTES_STATUS_WRITE_CMD 3'h2
`define FWP_BYTES_ADDR 3'h4
`define FWP_BYTES_PP 3'h5
`define FWP_SECT_MASK 24'hFFF000
`define FWP_BLK32_MASK 24'hFF8000
`define FWP_BLK64_MASK 24'hFF0000
`define FWP_L4_1 24'h07DFFF
`define FWP_L4_2 24'h07BFFF
`define FWP_L4_3 24'h077FFF
`define FWP_L4_4 24'h06FFFF
`define FWP_L4_5 24'h05FFFF
`define FWP_L4_6 24'h03FFFF
`define FWP_L4_7 24'h07FFFF
`define FWP_L2_1 24'h03DFFF
`define FWP_L2_2 24'h03BFFF
`define FWP_L2_3 24'h037FFF
`define FWP_L2_4 24'h02FFFF
`define FWP_L2_5 24'h01FFFF
`define FWP_L2_6 24'h03FFFF
`define FWP_MCLK_NS 8
`define FWP_PUW_US 10
`define FWP_TW_US 10
`define FWP_TPP_US 40
`define FWP_TSE_US 100
`define FWP_TBE_US 200
`define FWP_TCE_US 400
`define FWP_US2CYC(t) (((t) * 1000 + `FWP_MCLK_NS - 1) / `FWP_MCLK_NS)
`endif

/* File: logic/fwp_core.sv */
// Write-protection and program/erase gating of a serial NOR flash.
// Assumes a mode 0/3 serial host on spi_sclk and an array that ANDs program data in.
`timescale 1ns/10ps
`include "fwp_cfg.svh"
module fwp_core import fwp_pkg::*; #(
   parameter bit DENSITY_4M = 1'b1,
   parameter int PUW_CYCLES = `FWP_US2CYC(`FWP_PUW_US),
   parameter int TW_CYCLES = `FWP_US2CYC(`FWP_TW_US),
   parameter int TPP_CYCLES = `FWP_US2CYC(`FWP_TPP_US),
   parameter int TSE_CYCLES = `FWP_US2CYC(`FWP_TSE_US),
   parameter int TBE_CYCLES = `FWP_US2CYC(`FWP_TBE_US),
   parameter int TCE_CYCLES = `FWP_US2CYC(`FWP_TCE_US)
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_di,
   input wire logic wp_n,
   output logic spi_do,
   output logic spi_do_oe,
   output logic [7:0] status_register,
   output logic array_we,
   output logic [23:0] array_addr,
   output logic [7:0] array_wdata,
   output logic array_erase,
   output fwp_erase_type array_erase_kind
);
   logic link_rst;
   logic link_clr;
   logic [2:0] bit_cnt;
   logic [6:0] shift;
   logic [7:0] rx_byte;
   logic byte_tgl;
   logic frame_open;
   logic first_done;
   logic rd_active;
   logic [8:0] lstat_s1;
   logic [8:0] lstat_s2;
   logic cs_s1, cs_s2, cs_d3, cs_d4, cs_d5;
   logic wp_s1, wp_s2;
   logic tgl_s1, tgl_s2, tgl_s3;
   logic mid_s1, mid_s2;
   logic byte_evt, frame_beg, frame_end;
   logic [31:0] puw_cnt;
   logic puw_block;
   fwp_cmd_type cmd_state;
   logic [7:0] opcode;
   logic [2:0] byte_cnt;
   logic [23:0] cmd_addr;
   logic [7:0] data_cnt;
   logic wake_req;
   logic [7:0] page_mem [0:255];
   logic [255:0] page_valid;
   logic [7:0] wr_idx;
   logic pg_write, pg_clear;
   fwp_op_type op_state;
   logic [31:0] op_cnt;
   logic [8:0] prog_idx;
   logic [7:0] sr_new;
   logic lock, write_enable_latch, busy, deep_powerdown_state;
   logic [2:0] bp;
   logic whole, hw_prot, wr_gate, is_erase;
   logic att_status_write_cmd, att_prog, att_erase;
   logic go_status_write_cmd, go_prog, go_erase, deny;
   logic [23:0] er_base;
   fwp_erase_type er_kind;

   // Returns the last protected address of a protect code; code zero is never a hit.
   function automatic logic [23:0] fwp_limit(input logic [2:0] code);
      logic [23:0] lim;
      lim = 24'h000000;
      if (DENSITY_4M) begin
         case (code)
            3'h1: lim = `FWP_L4_1;
            3'h2: lim = `FWP_L4_2;
            3'h3: lim = `FWP_L4_3;
            3'h4: lim = `FWP_L4_4;
            3'h5: lim = `FWP_L4_5;
            3'h6: lim = `FWP_L4_6;
            default: lim = `FWP_L4_7;
         endcase
      end else begin
         case (code)
            3'h1: lim = `FWP_L2_1;
            3'h2: lim = `FWP_L2_2;
            3'h3: lim = `FWP_L2_3;
            3'h4: lim = `FWP_L2_4;
            3'h5: lim = `FWP_L2_5;
            default: lim = `FWP_L2_6;
         endcase
      end
      return lim;
   endfunction : fwp_limit

   // Protection always starts at address zero, so a region hits when its base is in range.
   function automatic logic fwp_hit(input logic [2:0] code, input logic [23:0] a);
      return (code != 3'h0) && (a <= fwp_limit(code));
   endfunction : fwp_hit

   // Link side. The link clock stands still between frames, so all state that must
   // outlive a frame is reset from the system side, never by a link edge.
   assign link_clr = spi_cs_n | link_rst;

   always_ff @(posedge spi_sclk or posedge link_rst) begin
      if (link_rst) begin
         bit_cnt <= 3'h0;
         shift <= 7'h00;
         rx_byte <= 8'h00;
         byte_tgl <= 1'b0;
         lstat_s1 <= 9'h000;
         lstat_s2 <= 9'h000;
      end else begin
         shift <= {shift[5:0], spi_di};
         lstat_s1 <= {deep_powerdown_state, status_register};
         lstat_s2 <= lstat_s1;
         if (!frame_open) begin
            bit_cnt <= 3'h1;
         end else begin
            bit_cnt <= bit_cnt + 3'h1;
         end
         if (frame_open && bit_cnt == 3'h7) begin
            rx_byte <= {shift, spi_di};
            byte_tgl <= ~byte_tgl;
         end
      end
   end

   always_ff @(posedge spi_sclk or posedge link_clr) begin
      if (link_clr) begin
         frame_open <= 1'b0;
         first_done <= 1'b0;
         rd_active <= 1'b0;
      end else begin
         frame_open <= 1'b1;
         if (frame_open && bit_cnt == 3'h7) begin
            first_done <= 1'b1;
            if (!first_done && {shift, spi_di} == `FWP_OP_RDSR && !lstat_s2[8]) begin
               rd_active <= 1'b1;
            end
         end
      end
   end

   // Status bits are quasi-static; a flag that flips mid-byte may show either value.
   always_ff @(negedge spi_sclk or posedge link_rst) begin
      if (link_rst) begin
         spi_do <= 1'b0;
      end else begin
         spi_do <= lstat_s2[3'h7 - bit_cnt];
      end
   end

   assign spi_do_oe = rd_active & ~spi_cs_n;

   // System side synchronisers. Frame end is seen two stages after the byte toggle so
   // that a last byte is always counted before the frame is judged.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         link_rst <= 1'b1;
         {cs_s1, cs_s2, cs_d3, cs_d4, cs_d5} <= 5'h1F;
         {wp_s1, wp_s2} <= 2'h3;
         {tgl_s1, tgl_s2, tgl_s3} <= 3'h0;
         {mid_s1, mid_s2} <= 2'h0;
      end else begin
         link_rst <= 1'b0;
         {cs_s1, cs_s2, cs_d3, cs_d4, cs_d5} <= {spi_cs_n, cs_s1, cs_s2, cs_d3, cs_d4};
         {wp_s1, wp_s2} <= {wp_n, wp_s1};
         {tgl_s1, tgl_s2, tgl_s3} <= {byte_tgl, tgl_s1, tgl_s2};
         {mid_s1, mid_s2} <= {bit_cnt != 3'h0, mid_s1};
      end
   end

   assign byte_evt = tgl_s2 ^ tgl_s3;
   assign frame_beg = !cs_s2 && cs_d3;
   assign frame_end = cs_d4 && !cs_d5;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         puw_cnt <= 32'(PUW_CYCLES);
      end else if (puw_cnt != 32'h0) begin
         puw_cnt <= puw_cnt - 32'h1;
      end
   end

   assign puw_block = puw_cnt != 32'h0;

   // Command parser held idle in reset.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cmd_state <= CMD_OFF;
         opcode <= 8'h00;
         byte_cnt <= 3'h0;
         cmd_addr <= 24'h000000;
         data_cnt <= 8'h00;
         wake_req <= 1'b0;
      end else begin
         wake_req <= 1'b0;
         if (frame_beg) begin
            cmd_state <= CMD_OPC;
            byte_cnt <= 3'h0;
            data_cnt <= 8'h00;
         end else if (frame_end) begin
            cmd_state <= CMD_OFF;
         end else if (byte_evt) begin
            case (cmd_state)
               CMD_OPC: begin
                  opcode <= rx_byte;
                  byte_cnt <= 3'h1;
                  if (busy || (deep_powerdown_state && rx_byte != `FWP_OP_WAKE)) begin
                     cmd_state <= CMD_SKIP;
                  end else begin
                     cmd_state <= CMD_BODY;
                     wake_req <= deep_powerdown_state;
                  end
               end
               CMD_BODY: begin
                  if (byte_cnt != 3'h7) begin
                     byte_cnt <= byte_cnt + 3'h1;
                  end
                  if (byte_cnt < `FWP_BYTES_ADDR) begin
                     cmd_addr <= {cmd_addr[15:0], rx_byte};
                  end else begin
                     data_cnt <= data_cnt + 8'h01;
                  end
               end
               CMD_SKIP: cmd_state <= CMD_SKIP;
               CMD_OFF: cmd_state <= CMD_OFF;
               default: cmd_state <= CMD_OFF;
            endcase
         end
      end
   end

   assign wr_idx = cmd_addr[7:0] + data_cnt;
   assign pg_write = byte_evt && cmd_state == CMD_BODY && byte_cnt >= `FWP_BYTES_ADDR
      && opcode == `FWP_OP_PP;
   assign pg_clear = byte_evt && cmd_state == CMD_OPC && !busy && !deep_powerdown_state;

   always_ff @(posedge mclk) begin
      if (pg_write) begin
         page_mem[wr_idx] <= rx_byte;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         page_valid <= '0;
      end else if (pg_clear) begin
         page_valid <= '0;
      end else if (pg_write) begin
         page_valid[wr_idx] <= 1'b1;
      end
   end

   always_comb begin
      er_kind = ER_SECTOR;
      er_base = cmd_addr & `FWP_SECT_MASK;
      is_erase = 1'b1;
      case (opcode)
         `FWP_OP_SE: er_kind = ER_SECTOR;
         `FWP_OP_BE32: begin
            er_kind = ER_BLK32;
            er_base = cmd_addr & `FWP_BLK32_MASK;
         end
         `FWP_OP_BE64: begin
            er_kind = ER_BLK64;
            er_base = cmd_addr & `FWP_BLK64_MASK;
         end
         `FWP_OP_CE1, `FWP_OP_CE2: begin
            er_kind = ER_CHIP;
            er_base = 24'h000000;
         end
         default: is_erase = 1'b0;
      endcase
   end

   assign whole = cmd_state == CMD_BODY && !mid_s2;
   assign hw_prot = lock && !wp_s2;
   assign wr_gate = frame_end && whole && write_enable_latch && !puw_block;
   assign att_status_write_cmd = wr_gate && opcode == `FWP_OP_STATUS_WRITE_CMD && byte_cnt == `FWP_BYTES_STATUS_WRITE_CMD;
   assign att_prog = wr_gate && opcode == `FWP_OP_PP && byte_cnt >= `FWP_BYTES_PP;
   assign att_erase = wr_gate && is_erase && (er_kind == ER_CHIP || byte_cnt == `FWP_BYTES_ADDR);
   assign go_status_write_cmd = att_status_write_cmd && !hw_prot;
   assign go_prog = att_prog && !fwp_hit(bp, cmd_addr);
   assign go_erase = att_erase && !fwp_hit(bp, er_base);
   assign deny = (att_status_write_cmd || att_prog || att_erase) && !(go_status_write_cmd || go_prog || go_erase);

   assign busy = op_state != OP_IDLE;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         op_state <= OP_IDLE;
         op_cnt <= 32'h0;
         prog_idx <= 9'h000;
         sr_new <= 8'h00;
         lock <= `FWP_LOCK_RESET;
         bp <= `FWP_BP_RESET;
         write_enable_latch <= 1'b0;
         deep_powerdown_state <= 1'b0;
      end else begin
         case (op_state)
            OP_IDLE: begin
               if (wake_req) begin
                  deep_powerdown_state <= 1'b0;
               end
               if (frame_end && whole) begin
                  if (opcode == `FWP_OP_WRDI) begin
                     write_enable_latch <= 1'b0;
                  end
                  if (opcode == `FWP_OP_WRITE_ENABLE_CMD && !puw_block) begin
                     write_enable_latch <= 1'b1;
                  end
                  if (opcode == `FWP_OP_DPD) begin
                     deep_powerdown_state <= 1'b1;
                  end
               end
               if (go_status_write_cmd) begin
                  op_state <= OP_STATUS_WRITE_CMD;
                  op_cnt <= 32'(TW_CYCLES - 1);
                  sr_new <= cmd_addr[7:0];
               end
               if (go_prog) begin
                  op_state <= OP_PROG;
                  op_cnt <= 32'(TPP_CYCLES - 1);
                  prog_idx <= 9'h000;
               end
               if (go_erase) begin
                  op_state <= OP_ERASE;
                  case (er_kind)
                     ER_SECTOR: op_cnt <= 32'(TSE_CYCLES - 1);
                     ER_CHIP: op_cnt <= 32'(TCE_CYCLES - 1);
                     default: op_cnt <= 32'(TBE_CYCLES - 1);
                  endcase
               end
               if (deny) begin
                  write_enable_latch <= 1'b0;
               end
            end
            OP_PROG, OP_STATUS_WRITE_CMD, OP_ERASE: begin
               if (op_state == OP_PROG && !prog_idx[8]) begin
                  prog_idx <= prog_idx + 9'h001;
               end
               if (op_cnt == 32'h0) begin
                  op_state <= OP_IDLE;
                  write_enable_latch <= 1'b0;
                  if (op_state == OP_STATUS_WRITE_CMD) begin
                     lock <= sr_new[`FWP_SR_LOCK];
                     bp <= sr_new[`FWP_SR_BP_HI:`FWP_SR_BP_LO];
                  end
               end else begin
                  op_cnt <= op_cnt - 32'h1;
               end
            end
            default: op_state <= OP_IDLE;
         endcase
      end
   end

   always_comb begin
      status_register = 8'h00;
      status_register[`FWP_SR_LOCK] = lock;
      status_register[`FWP_SR_BP_HI:`FWP_SR_BP_LO] = bp;
      status_register[`FWP_SR_WEL] = write_enable_latch;
      status_register[`FWP_SR_BUSY] = busy;
   end

   // The array ANDs program data into the cell, so bits only fall from 1 to 0.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         array_we <= 1'b0;
         array_addr <= 24'h000000;
         array_wdata <= 8'h00;
         array_erase <= 1'b0;
         array_erase_kind <= ER_SECTOR;
      end else begin
         array_we <= op_state == OP_PROG && !prog_idx[8] && page_valid[prog_idx[7:0]];
         array_wdata <= page_mem[prog_idx[7:0]];
         array_erase <= go_erase;
         if (go_erase) begin
            array_addr <= er_base;
            array_erase_kind <= er_kind;
         end else if (op_state == OP_PROG) begin
            array_addr <= {cmd_addr[23:8], prog_idx[7:0]};
         end
      end
   end
endmodule : fwp_core

/* File: logic/fwp_pkg.sv */
// Types of the flash write-protection block.
// Assumes nothing of its surroundings.
package fwp_pkg;
   typedef enum logic [3:0] {
      CMD_OFF = 4'h1,
      CMD_OPC = 4'h2,
      CMD_BODY = 4'h4,
      CMD_SKIP = 4'h8
   } fwp_cmd_type;
   typedef enum logic [3:0] {
      OP_IDLE = 4'h1,
      OP_PROG = 4'h2,
      OP_STATUS_WRITE_CMD = 4'h4,
      OP_ERASE = 4'h8
   } fwp_op_type;
   typedef enum logic [1:0] {
      ER_SECTOR = 2'h0,
      ER_BLK32 = 2'h1,
      ER_BLK64 = 2'h2,
      ER_CHIP = 2'h3
   } fwp_erase_type;
endpackage : fwp_pkg

/* File: tb/flash_write_protection_bench.sv */
// Self-checking bench for the flash write-protection core, driven through a serial host model.
// Assumes shortened operation counts set at the instance below; the power-up delay keeps its default.
`timescale 1ns/10ps
`include "fwp_cfg.svh"
module flash_write_protection_bench;
   import fwp_pkg::*;
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic wp_n = 1'b1;
   wire sclk, cs_n, di, sdo, sdo_oe, we, er;
   wire [7:0] sr, wdata;
   wire [23:0] addr;
   fwp_erase_type kind;
   int n_fail = 0, compares = 0, cyc = 0, n_er = 0, n_we = 0, k;
   logic [23:0] er_addr, we_addr;
   logic [7:0] we_data, rd;
   fwp_erase_type er_kind;
   logic [23:0] lim [1:7] = '{24'h07DFFF, 24'h07BFFF, 24'h077FFF, 24'h06FFFF, 24'h05FFFF,
      24'h03FFFF, 24'h07FFFF};
   logic [7:0] ops [5] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
   fwp_erase_type kinds [5] = '{ER_SECTOR, ER_BLK32, ER_BLK64, ER_CHIP, ER_CHIP};
   fwp_core #(.TW_CYCLES(150), .TPP_CYCLES(300), .TSE_CYCLES(150),
      .TBE_CYCLES(150), .TCE_CYCLES(150)) u_fwp_core (.mclk(mclk), .nrst(nrst),
      .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_di(di), .wp_n(wp_n), .spi_do(sdo),
      .spi_do_oe(sdo_oe), .status_register(sr), .array_we(we), .array_addr(addr),
      .array_wdata(wdata), .array_erase(er), .array_erase_kind(kind));
   fwp_host_model u_fwp_host_model (.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_di(di),
      .spi_do(sdo), .spi_do_oe(sdo_oe));
   initial begin
      forever #4 mclk = ~mclk;
   end
   task automatic close_out;
      if (n_fail == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   always @(posedge mclk) begin
      cyc++;
      if (er) begin
         n_er++;
         er_addr = addr;
         er_kind = kind;
      end
      if (we) begin
         n_we++;
         we_addr = addr;
         we_data = wdata;
      end
      if (cyc == 40000) begin
         n_fail++;
         close_out();
      end
   end
   task automatic cmd(input logic [39:0] d, input int n);
      u_fwp_host_model.frame(d, n, rd);
      repeat (12) @(posedge mclk);
   endtask : cmd
   task automatic wen;
      cmd({8'h06, 32'h0}, 8);
   endtask : wen
   task automatic wait_idle;
      int t;
      t = 0;
      while (sr[0] !== 1'b0 && t < 3000) begin
         @(posedge mclk);
         t++;
      end
      `CHK("idle", 1'b0, sr[0])
   endtask : wait_idle
   task automatic wsr(input logic [7:0] v);
      wen;
      cmd({8'h01, v, 24'h0}, 16);
      wait_idle;
   endtask : wsr
   task automatic sect(input logic [23:0] a);
      wen;
      cmd({8'h20, a, 8'h0}, 32);
   endtask : sect
   initial begin
      repeat (2) @(posedge mclk);
      `CHK("sr_reset", 8'h00, sr)
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      wen;
      `CHK("wel_powerup", 1'b0, sr[1])
      repeat (`FWP_US2CYC(`FWP_PUW_US)) @(posedge mclk);
      cmd({8'h06, 32'h0}, 7);
      `CHK("wel_short", 1'b0, sr[1])
      cmd({8'h06, 32'h0}, 9);
      `CHK("wel_long", 1'b0, sr[1])
      wen;
      `CHK("wel_set", 1'b1, sr[1])
      cmd({8'h04, 32'h0}, 8);
      `CHK("wel_clear", 1'b0, sr[1])
      cmd({8'h01, 8'h9C, 24'h0}, 16);
      `CHK("sr_no_wel", 8'h00, sr)
      wen;
      cmd({8'h01, 8'h9F, 24'h0}, 16);
      u_fwp_host_model.frame({8'h05, 32'h0}, 16, rd);
      `CHK("poll_busy", 8'h03, rd)
      wait_idle;
      `CHK("sr_loaded", 8'h9C, sr)
      wp_n <= 1'b0;
      repeat (4) @(posedge mclk);
      wsr(8'h00);
      `CHK("hw_protect", 8'h9C, sr)
      wp_n <= 1'b1;
      repeat (4) @(posedge mclk);
      wsr(8'h00);
      `CHK("pin_high", 8'h00, sr)
      wp_n <= 1'b0;
      repeat (4) @(posedge mclk);
      wsr(8'h0C);
      `CHK("pin_ignored", 8'h0C, sr)
      wp_n <= 1'b1;
      for (int c = 1; c < 8; c++) begin
         wsr({3'b000, c[2:0], 2'b00});
         if (c < 7) begin
            sect(lim[c] + 24'h1);
            wait_idle;
            `CHK("free_erase", lim[c] + 24'h1, er_addr)
         end
         k = n_er;
         sect(lim[c] & 24'hFFF000);
         `CHK("prot_count", k, n_er)
         `CHK("prot_idle", 2'b00, sr[1:0])
      end
      wsr(8'h00);
      for (int i = 0; i < 5; i++) begin
         k = n_er;
         wen;
         cmd({ops[i], 24'h010000, 8'h0}, i < 3 ? 32 : 8);
         `CHK("erase_kind", kinds[i], er_kind)
         `CHK("erase_count", k + 1, n_er)
         cmd({8'h04, 32'h0}, 8);
         `CHK("busy_ignore", 2'b11, sr[1:0])
         wait_idle;
         `CHK("done_wel", 1'b0, sr[1])
      end
      k = n_we;
      wen;
      cmd({8'h02, 24'h000110, 8'hA5}, 40);
      wait_idle;
      `CHK("prog_count", k + 1, n_we)
      `CHK("prog_addr", 24'h000110, we_addr)
      `CHK("prog_data", 8'hA5, we_data)
      wen;
      cmd({8'h02, 24'h000120, 8'h5A}, 39);
      `CHK("prog_short", k + 1, n_we)
      `CHK("short_wel", 2'b10, sr[1:0])
      cmd({8'hB9, 32'h0}, 8);
      cmd({8'h04, 32'h0}, 8);
      `CHK("asleep_wel", 1'b1, sr[1])
      cmd({8'hAB, 32'h0}, 8);
      cmd({8'h04, 32'h0}, 8);
      `CHK("awake_wel", 1'b0, sr[1])
      wen;
      nrst <= 1'b0;
      repeat (2) @(posedge mclk);
      `CHK("mid_reset", 8'h00, sr)
      wen;
      `CHK("reset_deaf", 8'h00, sr)
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      wen;
      `CHK("wel_rewake", 1'b0, sr[1])
      close_out();
   end
endmodule : flash_write_protection_bench

/* File: tb/fwp_core_props.sv */
// Concurrent checks on the ports of the flash write-protection core.
// Assumes the core's mclk domain; the serial side is judged through status and through spi_cs_n and spi_do_oe.
`timescale 1ns/10ps
module fwp_core_props import fwp_pkg::*; (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic spi_cs_n,
   input wire logic spi_do_oe,
   input wire logic [7:0] status_register,
   input wire logic array_we,
   input wire logic array_erase,
   input wire logic [23:0] array_addr,
   input wire fwp_erase_type array_erase_kind
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_busy_start;
      $rose(status_register[0]);
   endsequence
   sequence s_busy_end;
      $fell(status_register[0]);
   endsequence
   a_reset_clears_all: assert property (disable iff (1'b0) !nrst |=>
      status_register == 8'h00 && !array_we && !array_erase) else $error("reset left state");
   a_reserved_bits_zero: assert property (status_register[6:5] == 2'b00)
      else $error("reserved status bits set");
   a_start_needs_wel: assert property (s_busy_start |-> status_register[1])
      else $error("operation started without write enable");
   a_end_clears_wel: assert property (s_busy_end |-> !status_register[1])
      else $error("write enable kept after operation");
   a_erase_one_shot: assert property (array_erase |-> status_register[0] ##1 !array_erase)
      else $error("erase pulse outside busy or too long");
   a_prog_while_busy: assert property (array_we |-> status_register[0] && !array_erase)
      else $error("program pulse while idle");
   a_no_wen_busy: assert property ($rose(status_register[1]) |->
      !status_register[0] && !$past(status_register[0]))
      else $error("write enable taken while busy");
   a_bits_load_end: assert property ($changed(status_register[7:2]) |->
      !status_register[0] && ($past(status_register[0]) || $past(status_register[0], 2)))
      else $error("status bits moved early");
   a_drive_in_frame: assert property ((spi_cs_n || $fell(spi_cs_n)) |-> !spi_do_oe)
      else $error("data out driven outside frame");
   a_erase_base_aligned: assert property (array_erase && array_erase_kind != ER_CHIP |->
      array_addr[11:0] == 12'h000) else $error("erase base not aligned");
endmodule : fwp_core_props
bind fwp_core fwp_core_props u_fwp_core_props (.mclk(mclk), .nrst(nrst), .spi_cs_n(spi_cs_n),
   .spi_do_oe(spi_do_oe), .status_register(status_register), .array_we(array_we),
   .array_erase(array_erase), .array_addr(array_addr), .array_erase_kind(array_erase_kind));

/* File: tb/fwp_host_model.sv */
// Behavioural serial host in mode 0 that frames commands for the flash core.
// Assumes the caller leaves time between frames; its clock runs only inside a frame.
`timescale 1ns/10ps
module fwp_host_model (
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_di,
   input wire logic spi_do,
   input wire logic spi_do_oe
);
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_di = 1'b0;
   end
   // the first n bits of d, MSB first.
   // Count n is chosen by the caller so that a short last byte can be sent on purpose.
   task automatic frame(input logic [39:0] d, input int n, output logic [7:0] rd);
      #3.3 spi_cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         spi_di = d[39-i];
         #24 spi_sclk = 1'b1;
         // An undriven output has no pull, so the model reads it as the inverse of its level.
         rd = {rd[6:0], spi_do_oe ? spi_do : ~spi_do};
         #24 spi_sclk = 1'b0;
      end
      #24 spi_cs_n = 1'b1;
      // A released line must not keep showing the last bit.
      spi_di = ~spi_di;
      #60;
   endtask : frame
endmodule : fwp_host_model
